// ---- sas_sequencer.sv ----
// segmented acquisition sequencer with AXI4-Lite register slave
`timescale 1ns/1ps

module sas_sequencer
  import sas_pkg::*;
#(
  parameter int SEG_W = 8  // segment index width, stamp memory depth 2**SEG_W
)(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              trigIn,        // trigger circuit output pin
  input  wire logic              extClkIn,      // external_input used as sample clock
  input  wire logic              fastAdapterIn, // fast timebase adapter present
  output logic                   sampleStrobe,  // ADC sample clock pulse
  output logic                   memWrEn,       // write current sample to memory
  output logic [31:0]            memWrAddr,
  output logic [3:0]             adcChanEnable, // enabled channels 1..4
  output logic [1:0]             adcInterleave, // 0 separate, 1 paired, 2 all four
  output logic                   segDone,       // pulse: segment complete
  output logic [SEG_W-1:0]       segDoneIdx,
  output logic                   acqDone        // pulse: whole sequence complete
);

  // all state of the block except the stamp memory
  typedef struct packed {
    logic             awReady, wReady, bValid, awHeld, wHeld, arReady, rValid;
    logic [1:0]       bResp, rResp;
    logic [7:0]       awAddr;
    logic [31:0]      wData;
    logic [3:0]       wStrb;
    logic [31:0]      rData;
    logic [31:0]      ctrl, tdiv, segs, maxSeg, totMem, timeout, delay;
    logic [SEG_W-1:0] stampSel;
    logic             trigS1, trigS2, trigS3, extS1, extS2, extS3, adpS1, adpS2;
    sas_state_t       st;
    logic [SEG_W-1:0] seg, newest;
    logic [31:0]      segBase, sampleCnt, intervalCnt, delayCnt, toCnt, tsCnt;
    logic             seenTrig, extActive, extLocked, wrapped, done;
    logic [5:0]       extEdges;
    logic             stampWe;
    logic [SEG_W-1:0] stampIdx;
    logic [31:0]      stampVal;
    logic             sampleStrobe, memWrEn, segDone, acqDone;
    logic [31:0]      memWrAddr;
    logic [3:0]       adcChanEnable;
    logic [1:0]       adcInterleave;
    logic [SEG_W-1:0] segDoneIdx;
  } sas_regs_t;

  sas_regs_t s;      // registered state
  sas_regs_t next_s; // next state

  logic [31:0] stampMem [2**SEG_W]; // one trigger stamp per segment

  // byte lane merge for AXI writes
  function automatic logic [31:0] sas_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    return r;
  endfunction : sas_merge

  // smaller of two
  function automatic logic [31:0] sas_min(input logic [31:0] a, input logic [31:0] b);
    return (a < b) ? a : b;
  endfunction : sas_min

  // division guarded against zero, result at least one
  function automatic logic [31:0] sas_div(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] q;
    q = (b == 32'h0000_0000) ? a : a / b;
    return (q == 32'h0000_0000) ? 32'h0000_0001 : q;
  endfunction : sas_div

  // derived settings, decoded from registers
  sas_trig_t   trigMode;   // effective trigger mode
  sas_seq_t    seqMode;
  logic        extMode;    // ext sample clock in control
  logic [31:0] memTotal, segsEff, perSeg, winLen, interval;
  logic [2:0]  chanUse;
  logic        trigEdge, extRise, sampleTick, timedOut, lastSeg;

  always_comb
  begin
    extMode  = s.extActive;
    // ext clock allows only single shot
    trigMode = extMode ? SAS_SINGLE : sas_trig_t'(s.ctrl[CTRL_TRIG_LSB +: 2]);
    seqMode  = sas_seq_t'(s.ctrl[CTRL_SEQ_LSB +: 2]);
    chanUse  = s.ctrl[CTRL_USE_LSB +: 3];
    // adapter quadruples memory, pairing doubles it
    if (s.adpS2)
      memTotal = {s.totMem[29:0], 2'b00};
    else if (chanUse == 3'(CHAN_USE_PAIRED))
      memTotal = {s.totMem[30:0], 1'b0};
    else
      memTotal = s.totMem;
    // segment count of zero or sequence off behaves as one segment
    segsEff = (seqMode == SAS_SEQ_OFF || s.segs == 32'h0000_0000) ? 32'h0000_0001 : s.segs;
    // window is ten divisions; divisions are samples under ext clock
    winLen  = 32'(WINDOW_DIVS * s.tdiv);
    perSeg  = sas_min(s.maxSeg, sas_div(memTotal, segsEff));
    if (extMode)
      perSeg = sas_min(perSeg, winLen);
    interval = sas_div(winLen, perSeg);
    lastSeg  = (32'(s.seg) == segsEff - 32'h0000_0001);
    // edges seen only on the second and third synchroniser stages
    trigEdge = s.trigS2 && !s.trigS3;
    extRise  = s.extS2 && !s.extS3;
    // sample tick: ext edges after lock, else the interval divider
    if (extMode)
      sampleTick = extRise && s.extLocked;
    else
      sampleTick = (s.intervalCnt >= interval - 32'h0000_0001);
    // no timeout under ext clock
    timedOut = !extMode && trigMode == SAS_AUTO && seqMode != SAS_SEQ_OFF && s.seenTrig &&
               s.timeout != 32'h0000_0000 && s.toCnt >= s.timeout;
  end

  // AXI read data multiplexer
  logic [31:0] rdMux;
  logic        rdHit;
  always_comb
  begin
    rdHit = 1'b1;
    unique case (s_axi_araddr)
      REG_CTRL:     rdMux = s.ctrl;
      REG_STATUS:   rdMux = {8'h00, 8'(s.newest), 8'(s.seg), 3'b000, s.wrapped, s.extActive,
                             s.extLocked, s.done, (s.st != SAS_IDLE && s.st != SAS_STOPPED)};
      REG_TDIV:     rdMux = s.tdiv;
      REG_SEGS:     rdMux = s.segs;
      REG_MAXSEG:   rdMux = s.maxSeg;
      REG_TOTMEM:   rdMux = s.totMem;
      REG_TIMEOUT:  rdMux = s.timeout;
      REG_DELAY:    rdMux = s.delay;
      REG_PERSEG:   rdMux = perSeg;
      REG_INTERVAL: rdMux = interval;
      REG_STAMPSEL: rdMux = 32'(s.stampSel);
      REG_STAMP:    rdMux = stampMem[s.stampSel];
      default:
      begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b0;
      end
    endcase
  end

  // next state of bus slave, settings and sequencer
  logic doWrite, startReq, stopReq, tdivWrite;
  always_comb
  begin
    next_s = s;
    // one cycle pulses drop by default
    next_s.segDone = 1'b0;
    next_s.acqDone = 1'b0;
    next_s.memWrEn = 1'b0;
    next_s.stampWe = 1'b0;
    next_s.sampleStrobe = 1'b0;
    startReq  = 1'b0;
    stopReq   = 1'b0;
    tdivWrite = 1'b0;

    // synchronisers for pins
    next_s.trigS1 = trigIn;
    next_s.trigS2 = s.trigS1;
    next_s.trigS3 = s.trigS2;
    next_s.extS1  = extClkIn;
    next_s.extS2  = s.extS1;
    next_s.extS3  = s.extS2;
    next_s.adpS1  = fastAdapterIn;
    next_s.adpS2  = s.adpS1;

    // write address and data are taken in either order
    if (s_axi_awvalid && s.awReady)
    begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wReady)
    begin
      next_s.wHeld = 1'b1;
      next_s.wData = s_axi_wdata;
      next_s.wStrb = s_axi_wstrb;
    end
    if (s.bValid && s_axi_bready)
      next_s.bValid = 1'b0;
    doWrite = s.awHeld && s.wHeld && !s.bValid;
    if (doWrite)
    begin
      next_s.awHeld = 1'b0;
      next_s.wHeld  = 1'b0;
      next_s.bValid = 1'b1;
      next_s.bResp  = RESP_OKAY;
      unique case (s.awAddr)
        REG_CTRL:
        begin
          next_s.ctrl = sas_merge(s.ctrl, s.wData, s.wStrb);
          startReq = s.wStrb[0] && s.wData[CTRL_START];
          stopReq  = s.wStrb[0] && s.wData[CTRL_STOP];
          // pulse bits never stored
          next_s.ctrl[CTRL_START] = 1'b0;
          next_s.ctrl[CTRL_STOP]  = 1'b0;
        end
        REG_TDIV:
        begin
          next_s.tdiv = sas_merge(s.tdiv, s.wData, s.wStrb);
          tdivWrite = 1'b1;
        end
        REG_SEGS:     next_s.segs = sas_merge(s.segs, s.wData, s.wStrb);
        REG_MAXSEG:   next_s.maxSeg = sas_merge(s.maxSeg, s.wData, s.wStrb);
        REG_TOTMEM:   next_s.totMem = sas_merge(s.totMem, s.wData, s.wStrb);
        REG_TIMEOUT:  next_s.timeout = sas_merge(s.timeout, s.wData, s.wStrb);
        REG_DELAY:    next_s.delay = sas_merge(s.delay, s.wData, s.wStrb);
        REG_STAMPSEL: next_s.stampSel = s.wData[SEG_W-1:0];
        REG_STATUS, REG_PERSEG, REG_INTERVAL, REG_STAMP: ; // read only, write ignored
        default:      next_s.bResp = RESP_SLVERR;
      endcase
    end
    next_s.awReady = !next_s.awHeld;
    next_s.wReady  = !next_s.wHeld;

    // read: answer registered on the taking edge
    if (s.rValid && s_axi_rready)
      next_s.rValid = 1'b0;
    if (s_axi_arvalid && s.arReady)
    begin
      next_s.rValid = 1'b1;
      next_s.rData  = rdMux;
      next_s.rResp  = rdHit ? RESP_OKAY : RESP_SLVERR;
    end
    next_s.arReady = !next_s.rValid;

    // ext clock kept only while trigger source is not the external input
    next_s.extActive = next_s.ctrl[CTRL_EXTCLK] && !next_s.ctrl[CTRL_TRIGEXT];
    // any time per division change returns to the internal clock
    if (tdivWrite)
    begin
      next_s.extActive = 1'b0;
      next_s.ctrl[CTRL_EXTCLK] = 1'b0;
    end
    // lock after fifty edges; restarts whenever ext mode is left
    if (!s.extActive)
    begin
      next_s.extEdges  = 6'h00;
      next_s.extLocked = 1'b0;
    end
    else if (extRise && !s.extLocked)
    begin
      next_s.extEdges = s.extEdges + 6'h01;
      if (s.extEdges == 6'(EXT_LOCK_EDGES - 1))
        next_s.extLocked = 1'b1;
    end

    // channel routing follows the adapter if present, else the channel use setting
    if (s.adpS2)
    begin
      next_s.adcChanEnable = 4'h2;
      next_s.adcInterleave = 2'h2;
    end
    else if (chanUse == 3'(CHAN_USE_PAIRED))
    begin
      next_s.adcChanEnable = s.ctrl[CTRL_FOURCH] ? 4'h6 : 4'h2;
      next_s.adcInterleave = 2'h1;
    end
    else
    begin
      next_s.adcChanEnable = s.ctrl[CTRL_FOURCH] ? 4'hf : 4'h3;
      next_s.adcInterleave = 2'h0;
    end

    // free running stamp time base and interval divider
    next_s.tsCnt = s.tsCnt + 32'h0000_0001;
    next_s.intervalCnt = sampleTick ? 32'h0000_0000 : s.intervalCnt + 32'h0000_0001;
    if (s.st != SAS_IDLE && s.st != SAS_STOPPED && s.toCnt != 32'hffff_ffff)
      next_s.toCnt = s.toCnt + 32'h0000_0001;

    // sequencer
    unique case (s.st)
      SAS_IDLE, SAS_STOPPED:
        if (startReq)
        begin
          next_s.st = SAS_ARM;
          next_s.seg = '0;
          next_s.segBase = 32'h0000_0000;
          next_s.wrapped = 1'b0;
          next_s.done = 1'b0;
          next_s.seenTrig = 1'b0;
        end
      SAS_ARM:
        if (timedOut)
        begin
          next_s.toCnt = 32'h0000_0000;
          if (seqMode == SAS_SEQ_WRAP)
          begin
            next_s.st = SAS_STOPPED;
            next_s.done = 1'b1;
            next_s.acqDone = 1'b1;
          end
          else
          begin
            next_s.seg = '0;
            next_s.segBase = 32'h0000_0000;
          end
        end
        else if (trigEdge)
        begin
          // trigger taken on clk; offset to the ext edge is not measured
          next_s.seenTrig = 1'b1;
          next_s.toCnt = 32'h0000_0000;
          next_s.stampWe = !extMode;
          next_s.stampIdx = s.seg;
          next_s.stampVal = s.tsCnt;
          next_s.delayCnt = s.delay;
          next_s.sampleCnt = 32'h0000_0000;
          next_s.st = (s.delay == 32'h0000_0000) ? SAS_CAPTURE : SAS_DELAY;
        end
      SAS_DELAY:
        // delay counts samples under ext clock, clk cycles otherwise
        if (!extMode || sampleTick)
        begin
          next_s.delayCnt = s.delayCnt - 32'h0000_0001;
          if (s.delayCnt == 32'h0000_0001)
            next_s.st = SAS_CAPTURE;
        end
      SAS_CAPTURE:
        if (sampleTick)
        begin
          next_s.sampleStrobe = 1'b1;
          next_s.memWrEn = 1'b1;
          next_s.memWrAddr = s.segBase + s.sampleCnt;
          next_s.sampleCnt = s.sampleCnt + 32'h0000_0001;
          // segment ends only after its full sample count
          if (s.sampleCnt == perSeg - 32'h0000_0001)
          begin
            next_s.segDone = 1'b1;
            next_s.segDoneIdx = s.seg;
            next_s.newest = s.seg;
            next_s.st = SAS_ARM;
            if (!lastSeg)
            begin
              next_s.seg = s.seg + 1'b1;
              next_s.segBase = s.segBase + perSeg;
            end
            else
            begin
              next_s.seg = '0;
              next_s.segBase = 32'h0000_0000;
              if (seqMode == SAS_SEQ_WRAP)
                next_s.wrapped = 1'b1;
              else
              begin
                next_s.acqDone = 1'b1;
                if (trigMode == SAS_SINGLE)
                begin
                  next_s.st = SAS_STOPPED;
                  next_s.done = 1'b1;
                end
              end
            end
          end
        end
      default: next_s.st = SAS_IDLE;
    endcase

    // stop request ends any running acquisition
    if (stopReq && s.st != SAS_IDLE && s.st != SAS_STOPPED)
    begin
      next_s.st = SAS_STOPPED;
      next_s.done = 1'b1;
      next_s.acqDone = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s <= '0;
      s.st <= SAS_IDLE;
      s.ctrl <= RST_CTRL;
      s.tdiv <= RST_TDIV;
      s.segs <= RST_SEGS;
      s.maxSeg <= RST_MAXSEG;
      s.totMem <= RST_TOTMEM;
      s.timeout <= RST_TIMEOUT;
      s.adcChanEnable <= 4'h3;
    end
    else
      s <= next_s;
  end

  // stamp memory, no reset needed for data
  always_ff @(posedge clk)
  begin
    if (s.stampWe)
      stampMem[s.stampIdx] <= s.stampVal;
  end

  // outputs straight from flip-flops
  assign s_axi_awready = s.awReady;
  assign s_axi_wready  = s.wReady;
  assign s_axi_bresp   = s.bResp;
  assign s_axi_bvalid  = s.bValid;
  assign s_axi_arready = s.arReady;
  assign s_axi_rdata   = s.rData;
  assign s_axi_rresp   = s.rResp;
  assign s_axi_rvalid  = s.rValid;
  assign sampleStrobe  = s.sampleStrobe;
  assign memWrEn       = s.memWrEn;
  assign memWrAddr     = s.memWrAddr;
  assign adcChanEnable = s.adcChanEnable;
  assign adcInterleave = s.adcInterleave;
  assign segDone       = s.segDone;
  assign segDoneIdx    = s.segDoneIdx;
  assign acqDone       = s.acqDone;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_seg_len;
    s.st == SAS_CAPTURE |-> s.sampleCnt < perSeg;
  endproperty
  a_seg_len: assert property (p_seg_len) else $error("segment overran its length");

  property p_stamp;
    s.st == SAS_ARM && trigEdge && !timedOut && !extMode
      |=> s.stampWe && s.stampVal == $past(s.tsCnt);
  endproperty
  a_stamp: assert property (p_stamp) else $error("trigger stamp not recorded");

  property p_single_hold;
    s.st == SAS_STOPPED && !startReq |=> s.st == SAS_STOPPED;
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("left stopped without start");

  property p_restart;
    s.segDone && seqMode == SAS_SEQ_ON && trigMode != SAS_SINGLE &&
    32'(s.segDoneIdx) == segsEff - 32'h0000_0001 |-> s.seg == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("sequence did not restart");

  property p_wrap_to;
    s.st == SAS_ARM && timedOut && seqMode == SAS_SEQ_WRAP |=> s.st == SAS_STOPPED ##1 s.done;
  endproperty
  a_wrap_to: assert property (p_wrap_to) else $error("wrap timeout did not stop");

  property p_advance;
    s.st == SAS_CAPTURE && sampleTick && s.sampleCnt == perSeg - 1 && !lastSeg && !stopReq
      |=> s.seg == $past(s.seg) + 1'b1;
  endproperty
  a_advance: assert property (p_advance) else $error("segment index did not advance");

  property p_ext_trig;
    s.ctrl[CTRL_TRIGEXT] |-> !s.extActive;
  endproperty
  a_ext_trig: assert property (p_ext_trig) else $error("ext clock with ext trigger");

  property p_tdiv_drop;
    tdivWrite |=> !s.extActive;
  endproperty
  a_tdiv_drop: assert property (p_tdiv_drop) else $error("ext clock kept after tdiv write");

  property p_lock;
    s.extActive && !s.extLocked |=> !s.sampleStrobe || !$past(s.extActive);
  endproperty
  a_lock: assert property (p_lock) else $error("ext sample before lock");

  property p_pair;
    chanUse == 3'(CHAN_USE_PAIRED) && !s.adpS2 |=> !s.adcChanEnable[0] && s.adcInterleave == 2'h1;
  endproperty
  a_pair: assert property (p_pair) else $error("paired mode left channel 1 on");

endmodule : sas_sequencer

// ---- sas_pkg.sv ----
// constants, field layouts and types for the segmented acquisition sequencer
package sas_pkg;

  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] REG_CTRL     = 8'h00; // mode and control
  localparam logic [7:0] REG_STATUS   = 8'h04; // sequencer state, read only
  localparam logic [7:0] REG_TDIV     = 8'h08; // time per division in clk cycles
  localparam logic [7:0] REG_SEGS     = 8'h0c; // requested segment count
  localparam logic [7:0] REG_MAXSEG   = 8'h10; // max samples per segment
  localparam logic [7:0] REG_TOTMEM   = 8'h14; // base memory in samples
  localparam logic [7:0] REG_TIMEOUT  = 8'h18; // auto trigger timeout, clk cycles
  localparam logic [7:0] REG_DELAY    = 8'h1c; // post trigger delay
  localparam logic [7:0] REG_PERSEG   = 8'h20; // derived samples per segment, read only
  localparam logic [7:0] REG_INTERVAL = 8'h24; // derived clk cycles per sample, read only
  localparam logic [7:0] REG_STAMPSEL = 8'h28; // segment whose stamp is read
  localparam logic [7:0] REG_STAMP    = 8'h2c; // trigger stamp of selected segment

  // control register field positions
  localparam int CTRL_START    = 0;  // write 1: arm, self clearing
  localparam int CTRL_STOP     = 1;  // write 1: stop request, self clearing
  localparam int CTRL_TRIG_LSB = 2;  // trigger mode, two bits
  localparam int CTRL_SEQ_LSB  = 4;  // sequence mode, two bits
  localparam int CTRL_EXTCLK   = 6;  // external sample clock request
  localparam int CTRL_TRIGEXT  = 7;  // trigger source is the external input
  localparam int CTRL_FOURCH   = 8;  // four channel unit
  localparam int CTRL_USE_LSB  = 9;  // channel use value, three bits
  localparam int CTRL_UPPER    = 12; // stored but never read; paired four channel unit enables channels 2 and 3 unless the adapter is present

  // status register field positions
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DONE    = 1;
  localparam int STAT_LOCKED  = 2;
  localparam int STAT_EXTACT  = 3;
  localparam int STAT_WRAPPED = 4;
  localparam int STAT_SEG_LSB = 8;
  localparam int STAT_NEW_LSB = 16;

  // reset values
  localparam logic [31:0] RST_CTRL    = 32'h0000_0208; // single trigger, channel use 1
  localparam logic [31:0] RST_TDIV    = 32'h0000_0064;
  localparam logic [31:0] RST_SEGS    = 32'h0000_0001;
  localparam logic [31:0] RST_MAXSEG  = 32'h0000_0100;
  localparam logic [31:0] RST_TOTMEM  = 32'h0000_1000;
  localparam logic [31:0] RST_TIMEOUT = 32'h0000_0000; // zero disables timeout

  // counts
  localparam int WINDOW_DIVS     = 10; // divisions per capture window
  localparam int EXT_LOCK_EDGES  = 50; // ext clock edges before it is trusted
  localparam int CHAN_USE_PAIRED = 2;  // channel use value that pairs ADCs

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    SAS_AUTO   = 2'b00,
    SAS_NORM   = 2'b01,
    SAS_SINGLE = 2'b10
  } sas_trig_t;

  typedef enum logic [1:0] {
    SAS_SEQ_OFF  = 2'b00,
    SAS_SEQ_ON   = 2'b01,
    SAS_SEQ_WRAP = 2'b10
  } sas_seq_t;

  typedef enum logic [2:0] {
    SAS_IDLE    = 3'b000,
    SAS_ARM     = 3'b001,
    SAS_DELAY   = 3'b010,
    SAS_CAPTURE = 3'b011,
    SAS_STOPPED = 3'b100
  } sas_state_t;

endpackage : sas_pkg

// ---- sas_far_end.sv ----
// far side model: trigger circuit and external sample clock source
`timescale 1ns/1ps
module sas_far_end (
  input  wire logic clk,
  input  wire logic trigReq,  // bench asks for one trigger
  input  wire logic extRun,   // clock source switched on
  output logic      trigIn,   // trigger circuit output
  output logic      extClkIn  // external sample clock
);
  logic [2:0] hold = 3'h0; // trigger high time left
  // clock runs only while switched on, idles low, phase unrelated to clk
  initial
  begin
    extClkIn = 1'b0;
    #1.3;
    forever #32 extClkIn = extRun ? ~extClkIn : 1'b0;
  end
  // four cycle pulse, safely above the two cycle minimum width
  always @(posedge clk) hold <= trigReq ? 3'h4 : hold - 3'(hold != 3'h0);
  assign trigIn = hold != 3'h0;
endmodule : sas_far_end

// ---- sas_sequencer_test.sv ----
// self-checking bench for the segmented acquisition sequencer
`timescale 1ns/1ps
module sas_sequencer_test;
  import sas_pkg::*;
  logic        clk, rst, sampleStrobe, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, trigIn, extClkIn, fastAdapterIn, memWrEn, segDone, acqDone;
  logic        trigReq, extRun;             // far side controls
  logic [7:0]  s_axi_awaddr, s_axi_araddr, segDoneIdx, lastIdx;
  logic [31:0] s_axi_wdata, s_axi_rdata, memWrAddr, lastAddr;
  logic [3:0]  s_axi_wstrb, adcChanEnable;
  logic [1:0]  s_axi_bresp, s_axi_rresp, adcInterleave, r; // r: last response code
  int          n_errors = 0, check_count = 0, nWr = 0, nSeg = 0, nAcq = 0, sv;
  sas_sequencer dut_u (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigIn, .extClkIn, .fastAdapterIn,
    .sampleStrobe, .memWrEn, .memWrAddr, .adcChanEnable, .adcInterleave, .segDone,
    .segDoneIdx, .acqDone);
  sas_far_end far_u (.clk, .trigReq, .extRun, .trigIn, .extClkIn);
  // clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // counts of output pulses, compared as deltas by the tests
  always @(posedge clk)
  begin
    nWr += (memWrEn === 1'b1 && sampleStrobe === 1'b1);
    nSeg += (segDone === 1'b1);
    nAcq += (acqDone === 1'b1);
    lastIdx <= (segDone === 1'b1) ? segDoneIdx : lastIdx;
    lastAddr <= (memWrEn === 1'b1) ? memWrAddr : lastAddr;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one write; address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // one read, masked compare of the data
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(nm, s_axi_rdata & m, e);
  endtask : rc
  // arm in a mode, feed n triggers, each after the previous segment ends
  task automatic run(input logic [1:0] tm, sm, input int n, ea, ei);
    int w0, s0, a0;
    w0 = nWr;
    s0 = nSeg;
    a0 = nAcq;
    wr(REG_CTRL, 32'h201 | {26'h0, sm, tm, 2'b00});
    repeat (n)
    begin
      trigReq <= 1'b1;
      @(posedge clk);
      trigReq <= 1'b0;
      do @(posedge clk); while (segDone !== 1'b1);
      repeat (8) @(posedge clk);
    end
    chk("samples", nWr - w0, 16 * n);
    chk("segments", nSeg - s0, n);
    chk("acq done", nAcq - a0, ea);
    chk("last index", lastIdx, ei);
    chk("last addr", lastAddr, 16 * ei + 15);
  endtask : run
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // watchdog, well above the few thousand cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    stop_test();
  end
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {fastAdapterIn, trigReq, extRun} = 3'h0;
    s_axi_wstrb = 4'hf;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rc("ctrl reset", REG_CTRL, 32'hffff_ffff, RST_CTRL);
    rc("tdiv reset", REG_TDIV, 32'hffff_ffff, RST_TDIV);
    rc("mem reset", REG_TOTMEM, 32'hffff_ffff, RST_TOTMEM);
    rc("unmapped", 8'h30, 32'hffff_ffff, 32'h0);
    chk("read resp", r, RESP_SLVERR);
    wr(8'h30, 32'h1);
    chk("write resp", r, RESP_SLVERR);
    $display("test registers done");
    wr(REG_TDIV, 32'h8);
    wr(REG_SEGS, 32'h2);
    wr(REG_MAXSEG, 32'h10);
    wr(REG_TOTMEM, 32'h40);
    rc("per segment", REG_PERSEG, 32'hffff_ffff, 32'h10);
    rc("interval", REG_INTERVAL, 32'hffff_ffff, 32'h5);
    run(SAS_SINGLE, SAS_SEQ_ON, 2, 1, 1);
    rc("done", REG_STATUS, 32'h3, 32'h2);
    sv = nSeg;
    trigReq <= 1'b1;
    @(posedge clk);
    trigReq <= 1'b0;
    repeat (120) @(posedge clk);
    chk("extra trigger", nSeg - sv, 0);
    $display("test single done");
    run(SAS_NORM, SAS_SEQ_ON, 3, 1, 0);
    wr(REG_CTRL, 32'h206);
    rc("stopped", REG_STATUS, 32'h1, 32'h0);
    $display("test normal done");
    wr(REG_TIMEOUT, 32'hc8);
    run(SAS_AUTO, SAS_SEQ_WRAP, 3, 0, 0);
    sv = nAcq;
    repeat (250) @(posedge clk);
    chk("wrap timeout", nAcq - sv, 1);
    rc("wrapped", REG_STATUS, 32'h13, 32'h12);
    run(SAS_AUTO, SAS_SEQ_ON, 1, 0, 0);
    repeat (250) @(posedge clk);
    rc("auto restart", REG_STATUS, 32'hff00, 32'h0);
    wr(REG_CTRL, 32'h202);
    $display("test wrap and auto done");
    wr(REG_CTRL, 32'h400);
    repeat (3) @(posedge clk);
    chk("paired two", {adcChanEnable, adcInterleave}, 6'h09);
    wr(REG_CTRL, 32'h500);
    repeat (3) @(posedge clk);
    chk("paired four", {adcChanEnable, adcInterleave}, 6'h19);
    wr(REG_CTRL, 32'h900);
    repeat (3) @(posedge clk);
    chk("separate four", {adcChanEnable, adcInterleave}, 6'h3c);
    fastAdapterIn <= 1'b1;
    repeat (6) @(posedge clk);
    chk("adapter", adcInterleave, 2'd2);
    fastAdapterIn <= 1'b0;
    $display("test channels done");
    wr(REG_CTRL, 32'h2c0);
    rc("ext with ext trigger", REG_STATUS, 32'h8, 32'h0);
    wr(REG_CTRL, 32'h240);
    extRun <= 1'b1;
    repeat (384) @(posedge clk);
    rc("early lock", REG_STATUS, 32'h4, 32'h0);
    repeat (400) @(posedge clk);
    rc("locked", REG_STATUS, 32'hc, 32'hc);
    wr(REG_TDIV, 32'h8);
    rc("ext dropped", REG_CTRL, 32'h40, 32'h0);
    rc("internal again", REG_STATUS, 32'h8, 32'h0);
    extRun <= 1'b0;
    $display("test external clock done");
    stop_test();
  end
endmodule : sas_sequencer_test
